// ===== ta_gate.sv
// Timed-access key sequence and protected write window
`timescale 1ns/1ps
`default_nettype none
module ta_gate import wdt_pkg::*; (
   input wire logic clk,             // System clock
   input wire logic rstn,            // Sync reset, active low
   input wire logic key_wr,          // Write to key register
   input wire logic [7:0] key_data,  // Key byte
   input wire logic consume,         // Protected write done
   output logic window_open          // Protected writes allowed
);
   typedef struct packed {
      gate_t state;
      logic [4:0] cnt;
   } gate_st_t;

   gate_st_t st;
   gate_st_t next_st;

   always_comb begin
      next_st = st;
      case (st.state)
         G_IDLE: begin
            if (key_wr && key_data == TA_KEY1) begin
               next_st.state = G_KEY1;
               next_st.cnt = '0;
            end
         end
         G_KEY1: begin
            next_st.cnt = st.cnt + 5'h1;
            // Second key must come before 4 machine cycles pass
            if (key_wr && key_data == TA_KEY2 && st.cnt < TA_KEYGAP_CLKS - 5'h1) begin
               next_st.state = G_OPEN; // [RULE_13] [RULE_11]
               next_st.cnt = '0;
            end else if (key_wr && key_data == TA_KEY1) begin
               next_st.cnt = '0;
            end else if (key_wr || st.cnt == TA_KEYGAP_CLKS - 5'h1) begin
               next_st.state = G_IDLE; // [RULE_13]
            end
         end
         G_OPEN: begin
            next_st.cnt = st.cnt + 5'h1;
            // One protected write per key sequence
            if (consume || st.cnt == TA_WINDOW_CLKS - 5'h1) begin
               next_st.state = G_IDLE; // [RULE_12]
            end
         end
         default: begin
            next_st.state = G_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign window_open = (st.state == G_OPEN);
endmodule // ta_gate
`default_nettype wire

// ===== testbench.sv
// Self-checking testbench of the watchdog timer block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module testbench import wdt_pkg::*; ;
   logic CLK = 1'b0;
   logic RSTN = 1'b0;
   logic [7:0] AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA;
   logic [3:0] WSTRB;
   logic [1:0] BRESP, RRESP;
   logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
   logic ARVALID, ARREADY, RVALID, RREADY, WD_IRQ, EVT_IRQ, WD_SYS_RST, hang;
   int error_cnt = 0;
   int checks = 0;
   int rst_hi = 0;
   initial forever #12.5 CLK = ~CLK;
   always @(posedge CLK) if (WD_SYS_RST === 1'b1) rst_hi <= rst_hi + 1;
   // Short intervals of 16, 32, 64 and 128 clocks keep the run brief
   watchdog_timer_block #(.IVL0_LOG2(4), .IVL1_LOG2(5), .IVL2_LOG2(6), .IVL3_LOG2(7)) dut (
      .CLK(CLK), .RSTN(RSTN), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
      .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
      .WD_IRQ(WD_IRQ), .EVT_IRQ(EVT_IRQ), .WD_SYS_RST(WD_SYS_RST));
   wd_core_model core (
      .clk(CLK), .awaddr(AWADDR), .awvalid(AWVALID), .awready(AWREADY), .wdata(WDATA),
      .wstrb(WSTRB), .wvalid(WVALID), .wready(WREADY), .bresp(BRESP), .bvalid(BVALID),
      .bready(BREADY), .araddr(ARADDR), .arvalid(ARVALID), .arready(ARREADY),
      .rdata(RDATA), .rresp(RRESP), .rvalid(RVALID), .rready(RREADY), .hang(hang));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic results();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic give_up();
      error_cnt++;
      $display("CHECK FAILED t=%0t wait ran out", $time);
      results();
   endtask
   // Ends at a falling edge so outputs are settled when looked at
   task automatic clocks(input int n);
      repeat (n) @(negedge CLK);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [1:0] r;
      core.wr(a, {24'h000000, d}, 4'hf, r);
      if (hang === 1'b1) give_up();
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      core.rd(a, d, r);
      if (hang === 1'b1) give_up();
   endtask
   task automatic ta_wr(input logic [7:0] d);
      wr(OFS_TA, TA_KEY1);
      wr(OFS_TA, TA_KEY2);
      wr(OFS_CTRL, d);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      logic [31:0] a, b;
      logic [1:0] r;
      rd(OFS_CTRL, a, r);
      `CHK(a, {24'h000000, CTRL_RESET})
      rd(8'h1c, a, r);
      `CHK(r, RESP_SLVERR)
      core.wr(8'h1c, 32'h000000ff, 4'hf, r);
      `CHK(r, RESP_SLVERR)
      rd(OFS_COUNT, a, r);
      clocks(10);
      rd(OFS_COUNT, b, r);
      `CHK(b, a)
   endtask
   task automatic t_protect();
      logic [31:0] a;
      logic [1:0] r;
      wr(OFS_CTRL, 8'hfb);
      rd(OFS_CTRL, a, r);
      `CHK(a, 32'h00000040)
      core.wr(OFS_CTRL, 32'h00000000, 4'h0, r);
      `CHK(r, RESP_OKAY)
      rd(OFS_CTRL, a, r);
      `CHK(a, 32'h00000040)
      wr(OFS_CTRL, 8'h00);
   endtask
   task automatic t_gap();
      logic [31:0] a;
      logic [1:0] r;
      wr(OFS_TA, TA_KEY1);
      clocks(20);
      wr(OFS_TA, TA_KEY2);
      wr(OFS_CTRL, 8'h80);
      rd(OFS_CTRL, a, r);
      `CHK(a, 32'h00000000)
   endtask
   task automatic t_window();
      logic [31:0] a;
      logic [1:0] r;
      wr(OFS_TA, TA_KEY1);
      wr(OFS_TA, TA_KEY2);
      clocks(10);
      wr(OFS_CTRL, 8'h80);
      rd(OFS_CTRL, a, r);
      `CHK(a, 32'h00000000)
   endtask
   task automatic t_poll();
      logic [31:0] a, b;
      logic [1:0] r;
      ta_wr(8'h81);
      rd(OFS_CTRL, a, r);
      `CHK(a & 32'h00000081, 32'h00000080)
      clocks(40);
      rd(OFS_CTRL, a, r);
      `CHK(a[CTL_TMO], 1'b1)
      `CHK(WD_IRQ, 1'b0)
      `CHK(WD_SYS_RST, 1'b0)
      wr(OFS_CTRL, 8'h40);
      clocks(2);
      `CHK(WD_IRQ, 1'b0)
      wr(OFS_GIE, 8'h01);
      clocks(2);
      `CHK(WD_IRQ, 1'b1)
      wr(OFS_EVT_EN, 8'h01);
      clocks(2);
      `CHK(EVT_IRQ, 1'b1)
      wr(OFS_GIE, 8'h00);
      clocks(2);
      `CHK(WD_IRQ, 1'b0)
      ta_wr(8'h00);
      // A time-out in flight as the run bit drops sets the flag again
      ta_wr(8'h00);
      rd(OFS_CTRL, a, r);
      `CHK(a, 32'h00000000)
      rd(OFS_COUNT, a, r);
      clocks(10);
      rd(OFS_COUNT, b, r);
      `CHK(b, a)
      wr(OFS_EVT_CLR, 8'h03);
      clocks(2);
      `CHK(EVT_IRQ, 1'b0)
   endtask
   task automatic t_interval();
      logic [31:0] a;
      logic [1:0] r;
      ta_wr(8'hb1);
      clocks(60);
      rd(OFS_CTRL, a, r);
      `CHK(a[CTL_TMO], 1'b0)
      clocks(70);
      rd(OFS_CTRL, a, r);
      `CHK(a[CTL_TMO], 1'b1)
   endtask
   task automatic t_restart();
      int n0;
      n0 = rst_hi;
      ta_wr(8'hb3);
      // Restarts every ~51 clocks, well inside the 128-clock interval
      repeat (14) begin
         clocks(40);
         ta_wr(8'hb3);
      end
      `CHK(rst_hi, n0)
   endtask
   task automatic t_sysreset();
      logic [31:0] a;
      logic [1:0] r;
      int n;
      ta_wr(8'hf3);
      wr(OFS_GIE, 8'h01);
      n = 0;
      while (WD_IRQ !== 1'b1 && n < 300) begin
         clocks(1);
         n++;
      end
      if (n >= 300) give_up();
      n = 0;
      while (WD_SYS_RST !== 1'b1 && n < 600) begin
         clocks(1);
         n++;
      end
      if (n >= 600) give_up();
      `CHK(n, int'(POST_TIMEOUT_TICKS))
      n = 0;
      while (WD_SYS_RST === 1'b1 && n < 20) begin
         clocks(1);
         n++;
      end
      if (n >= 20) give_up();
      `CHK(n, int'(RST_PULSE_MC * CLKS_PER_MC))
      rd(OFS_CTRL, a, r);
      `CHK(a[CTL_CAUSE], 1'b1)
      rd(OFS_EVT_STAT, a, r);
      `CHK(a[EVT_RST], 1'b1)
      ta_wr(8'h00);
   endtask
   initial begin
      repeat (16) @(posedge CLK);
      RSTN <= 1'b1;
      t_reset();
      t_protect();
      t_gap();
      t_window();
      t_poll();
      t_interval();
      t_restart();
      t_sysreset();
      results();
   end
endmodule // testbench
`default_nettype wire

// ===== watchdog_timer_block.sv
// Watchdog timer with timed-access control and AXI4-Lite registers
// What this block does
// RULE_01 - Divider chain counts; two bits select interval
// RULE_02 - Restart bit resets count, then self-clears
// RULE_03 - Elapsed interval sets time-out flag, bit 3
// RULE_04 - Interrupt needs local and global enable
// RULE_05 - Reset 512 ticks after time-out if enabled
// RULE_06 - Reset lasts two machine cycles, sets cause
// RULE_07 - Interrupt and reset enabled independently
// RULE_08 - Flag still sets with both paths disabled
// RULE_09 - Protected bits written only via timed access
// RULE_10 - Software should restart before relying on it
// RULE_11 - Machine cycle equals four system clocks
// RULE_12 - Protected write only within 3 machine cycles
// RULE_13 - Key gap of 4 cycles opens nothing
// RULE_14 - Run bit gates counting and detection
// RULE_15 - Four interval lengths are power-of-two parameters
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_block import wdt_pkg::*; #(
   parameter int IVL0_LOG2 = 17,
   parameter int IVL1_LOG2 = 20,
   parameter int IVL2_LOG2 = 23,
   parameter int IVL3_LOG2 = 26
) (
   input wire logic CLK,               // 40 MHz system clock
   input wire logic RSTN,              // Sync reset, active low
   input wire logic [7:0] AWADDR,      // Write address
   input wire logic AWVALID,           // Write address valid
   output logic AWREADY,               // Write address ready
   input wire logic [31:0] WDATA,      // Write data
   input wire logic [3:0] WSTRB,       // Write strobes
   input wire logic WVALID,            // Write data valid
   output logic WREADY,                // Write data ready
   output logic [1:0] BRESP,           // Write response
   output logic BVALID,                // Write response valid
   input wire logic BREADY,            // Write response ready
   input wire logic [7:0] ARADDR,      // Read address
   input wire logic ARVALID,           // Read address valid
   output logic ARREADY,               // Read address ready
   output logic [31:0] RDATA,          // Read data
   output logic [1:0] RRESP,           // Read response
   output logic RVALID,                // Read data valid
   input wire logic RREADY,            // Read data ready
   output logic WD_IRQ,                // Watchdog interrupt request
   output logic EVT_IRQ,               // Event summary interrupt
   output logic WD_SYS_RST             // Watchdog system reset
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [7:0] wdata;
      logic wstrb0;
      logic run;
      logic restart;
      logic rst_en;
      logic cause;
      logic tmo;
      logic [1:0] sel;
      logic irq_en;
      logic gie;
      logic [1:0] evt_stat;
      logic [1:0] evt_en;
      phase_t phase;
      logic [9:0] post_cnt;
      logic [3:0] rst_cnt;
      logic wd_irq;
      logic evt_irq;
      logic sysrst;
   } wd_st_t;

   wd_st_t st;
   wd_st_t next_st;
   logic tmo_pulse;
   cnt_t count;
   logic ta_open;
   logic wr_exec;
   logic wr_ctrl;
   logic prot_ok;
   logic key_wr;
   logic rst_start;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   function automatic logic reg_hit(input logic [7:0] a);
      return a[1:0] == 2'h0 && a <= OFS_COUNT;
   endfunction

   function automatic logic [31:0] read_word(input wd_st_t s, input logic [7:0] a,
                                             input cnt_t c);
      case (a)
         OFS_CTRL: read_word = {24'h0, s.run, s.irq_en, s.sel, s.tmo, s.cause,
                                s.rst_en, s.restart};
         OFS_GIE: read_word = {31'h0, s.gie};
         OFS_EVT_STAT: read_word = {30'h0, s.evt_stat};
         OFS_EVT_EN: read_word = {30'h0, s.evt_en};
         OFS_COUNT: read_word = {6'h0, c};
         default: read_word = 32'h0;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // Sub-blocks
   // ---------------------------------------------------------------
   wd_divider_chain #(
      .IVL0_LOG2(IVL0_LOG2),
      .IVL1_LOG2(IVL1_LOG2),
      .IVL2_LOG2(IVL2_LOG2),
      .IVL3_LOG2(IVL3_LOG2)
   ) u_div (
      .clk(CLK),
      .rstn(RSTN),
      .run(st.run),
      .restart(st.restart || st.phase == PH_RESET),
      .sel(st.sel),
      .tmo_pulse(tmo_pulse),
      .count(count)
   );

   ta_gate u_gate (
      .clk(CLK),
      .rstn(RSTN),
      .key_wr(key_wr),
      .key_data(st.wdata),
      .consume(wr_ctrl),
      .window_open(ta_open)
   );

   // ---------------------------------------------------------------
   // Write strobes
   // ---------------------------------------------------------------
   assign wr_exec = st.aw_got && st.w_got && !st.bvalid && st.wstrb0 && reg_hit(st.awaddr);
   assign wr_ctrl = wr_exec && st.awaddr == OFS_CTRL;
   assign prot_ok = wr_ctrl && ta_open; // [RULE_09] [RULE_12]
   assign key_wr = wr_exec && st.awaddr == OFS_TA;
   assign rst_start = st.phase == PH_GRACE && !st.restart && st.run &&
                      st.post_cnt == POST_TIMEOUT_TICKS - 10'h1 && st.rst_en;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;
      // Bus write channels, taken in either order
      if (AWVALID && st.awready) begin
         next_st.awready = 1'b0;
         next_st.aw_got = 1'b1;
         next_st.awaddr = AWADDR;
      end
      if (WVALID && st.wready) begin
         next_st.wready = 1'b0;
         next_st.w_got = 1'b1;
         next_st.wdata = WDATA[7:0];
         next_st.wstrb0 = WSTRB[0];
      end
      if (st.aw_got && st.w_got && !st.bvalid) begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = reg_hit(st.awaddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (st.bvalid && BREADY) begin
         next_st.bvalid = 1'b0;
         next_st.awready = 1'b1;
         next_st.wready = 1'b1;
      end
      // Bus read channel
      if (ARVALID && st.arready) begin
         next_st.arready = 1'b0;
         next_st.rvalid = 1'b1;
         next_st.rdata = read_word(st, ARADDR, count);
         next_st.rresp = reg_hit(ARADDR) ? RESP_OKAY : RESP_SLVERR;
      end
      if (st.rvalid && RREADY) begin
         next_st.rvalid = 1'b0;
         next_st.arready = 1'b1;
      end

      // Control register; unprotected bits first
      next_st.restart = 1'b0; // [RULE_02]
      if (wr_ctrl) begin
         next_st.irq_en = st.wdata[CTL_IRQ_EN]; // [RULE_07]
         next_st.cause = st.wdata[CTL_CAUSE]; // [RULE_09]
      end
      if (prot_ok) begin
         next_st.run = st.wdata[CTL_RUN]; // [RULE_09]
         next_st.restart = st.wdata[CTL_RESTART]; // [RULE_02]
         next_st.rst_en = st.wdata[CTL_RST_EN]; // [RULE_07]
         next_st.tmo = st.wdata[CTL_TMO];
         next_st.sel = st.wdata[CTL_SEL_HI:CTL_SEL_LO]; // [RULE_01]
      end
      if (wr_exec && st.awaddr == OFS_GIE) begin
         next_st.gie = st.wdata[0];
      end
      if (wr_exec && st.awaddr == OFS_EVT_EN) begin
         next_st.evt_en = st.wdata[1:0];
      end
      if (wr_exec && st.awaddr == OFS_EVT_CLR) begin
         next_st.evt_stat = st.evt_stat & ~st.wdata[1:0];
      end

      // Hardware sets win over software clears
      if (tmo_pulse) begin
         next_st.tmo = 1'b1; // [RULE_03] [RULE_08]
         next_st.evt_stat[EVT_TMO] = 1'b1;
      end

      // Time-out, grace wait and reset pulse
      case (st.phase)
         PH_COUNT: begin
            if (tmo_pulse) begin
               next_st.phase = PH_GRACE; // [RULE_05]
               next_st.post_cnt = '0;
            end
         end
         PH_GRACE: begin
            if (st.restart) begin
               next_st.phase = PH_COUNT; // [RULE_05]
            end else if (st.run) begin
               next_st.post_cnt = st.post_cnt + 10'h1; // [RULE_14]
               if (st.post_cnt == POST_TIMEOUT_TICKS - 10'h1) begin
                  // Without reset enable only the flag remains
                  next_st.phase = st.rst_en ? PH_RESET : PH_COUNT; // [RULE_05] [RULE_07]
               end
            end
         end
         PH_RESET: begin
            next_st.rst_cnt = st.rst_cnt + 4'h1;
            if (st.rst_cnt == RST_PULSE_CLKS - 4'h1) begin
               next_st.phase = PH_COUNT; // [RULE_06] [RULE_11]
               next_st.sysrst = 1'b0;
            end
         end
         default: begin
            next_st.phase = PH_COUNT;
         end
      endcase
      if (rst_start) begin
         next_st.rst_cnt = '0;
         next_st.sysrst = 1'b1; // [RULE_05]
         next_st.cause = 1'b1; // [RULE_06]
         next_st.evt_stat[EVT_RST] = 1'b1;
      end

      // Outputs follow the new flag values
      next_st.wd_irq = next_st.tmo && next_st.irq_en && next_st.gie; // [RULE_04]
      next_st.evt_irq = |(next_st.evt_stat & next_st.evt_en);
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         st <= '0;
         st.awready <= 1'b1;
         st.wready <= 1'b1;
         st.arready <= 1'b1;
         {st.run, st.irq_en, st.sel, st.tmo, st.cause, st.rst_en, st.restart} <= CTRL_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign AWREADY = st.awready;
   assign WREADY = st.wready;
   assign BVALID = st.bvalid;
   assign BRESP = st.bresp;
   assign ARREADY = st.arready;
   assign RVALID = st.rvalid;
   assign RDATA = st.rdata;
   assign RRESP = st.rresp;
   assign WD_IRQ = st.wd_irq;
   assign EVT_IRQ = st.evt_irq;
   assign WD_SYS_RST = st.sysrst;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RSTN);

   restart_self_clear_a: assert property (st.restart |=> !st.restart) // [RULE_02]
      else $error("restart bit did not clear itself");
   timeout_flag_a: assert property (tmo_pulse |=> st.tmo && st.evt_stat[EVT_TMO]) // [RULE_03]
      else $error("time-out did not set the flag");
   wd_irq_gate_a: assert property (WD_IRQ == (st.tmo && st.irq_en && st.gie)) // [RULE_04]
      else $error("watchdog interrupt not gated by both enables");
   grace_length_a: assert property ($rose(WD_SYS_RST) |->  // [RULE_05]
      $past(st.phase) == PH_GRACE && $past(st.post_cnt) == POST_TIMEOUT_TICKS - 10'h1)
      else $error("reset before the grace wait ended");
   reset_needs_en_a: assert property ($rose(WD_SYS_RST) |-> $past(st.rst_en)) // [RULE_05]
      else $error("reset asserted while reset disabled");
   reset_pulse_a: assert property ($rose(WD_SYS_RST) |->  // [RULE_06]
      WD_SYS_RST [*8] ##1 !WD_SYS_RST)
      else $error("reset pulse is not two machine cycles");
   reset_cause_a: assert property ($rose(WD_SYS_RST) |-> st.cause) // [RULE_06]
      else $error("cause flag not set with reset");
   poll_flag_a: assert property (!st.irq_en && !st.rst_en && tmo_pulse |=>  // [RULE_08]
      st.tmo && !WD_IRQ)
      else $error("polled flag missing");
   locked_write_a: assert property (wr_ctrl && !ta_open |=>  // [RULE_09]
      st.run == $past(st.run) && st.sel == $past(st.sel) && st.rst_en == $past(st.rst_en))
      else $error("protected bit changed without timed access");
   open_write_a: assert property (prot_ok |=> st.sel == $past(st.wdata[5:4]) &&  // [RULE_12]
      st.run == $past(st.wdata[7]))
      else $error("protected write within window was lost");
   run_hold_a: assert property (!st.run && st.phase == PH_GRACE && !st.restart |=>  // [RULE_14]
      st.post_cnt == $past(st.post_cnt) && !$rose(WD_SYS_RST))
      else $error("grace wait advanced while stopped");
endmodule // watchdog_timer_block
`default_nettype wire

// ===== wd_core_model.sv
// Bus master model of the processor core driving the watchdog registers
`timescale 1ns/1ps
`default_nettype none
module wd_core_model (
   input wire logic clk,           // System clock
   output var logic [7:0] awaddr,  // Write address
   output var logic awvalid,       // Write address valid
   input wire logic awready,       // Write address ready
   output var logic [31:0] wdata,  // Write data
   output var logic [3:0] wstrb,   // Write strobes
   output var logic wvalid,        // Write data valid
   input wire logic wready,        // Write data ready
   input wire logic [1:0] bresp,   // Write response
   input wire logic bvalid,        // Write response valid
   output var logic bready,        // Write response ready
   output var logic [7:0] araddr,  // Read address
   output var logic arvalid,       // Read address valid
   input wire logic arready,       // Read address ready
   input wire logic [31:0] rdata,  // Read data
   input wire logic [1:0] rresp,   // Read response
   input wire logic rvalid,        // Read data valid
   output var logic rready,        // Read data ready
   output var logic hang           // A transfer never ended
);
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready, hang} = '0;
   end
   // ------------------------------------------------------------
   // Transfers
   // ------------------------------------------------------------
   // Handshakes are judged at the falling edge, as they stand for the coming rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      logic ha, hw, hb;
      int n;
      ha = 1'b0;
      hw = 1'b0;
      hb = 1'b0;
      n = 0;
      r = 2'b11;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!hb && n < 100) begin
         @(negedge clk);
         ha = awvalid && awready;
         hw = wvalid && wready;
         hb = bvalid && bready;
         r = bresp;
         @(posedge clk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         n++;
      end
      bready <= 1'b0;
      if (!hb) hang <= 1'b1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ha, hr;
      int n;
      ha = 1'b0;
      hr = 1'b0;
      n = 0;
      d = '0;
      r = 2'b11;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!hr && n < 100) begin
         @(negedge clk);
         ha = arvalid && arready;
         hr = rvalid && rready;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ha) arvalid <= 1'b0;
         n++;
      end
      rready <= 1'b0;
      if (!hr) hang <= 1'b1;
   endtask
endmodule // wd_core_model
`default_nettype wire

// ===== wd_divider_chain.sv
// Divider chain, counting while run is set, with selectable time-out tap
`timescale 1ns/1ps
`default_nettype none
module wd_divider_chain import wdt_pkg::*; #(
   parameter int IVL0_LOG2 = 17,
   parameter int IVL1_LOG2 = 20,
   parameter int IVL2_LOG2 = 23,
   parameter int IVL3_LOG2 = 26
) (
   input wire logic clk,        // System clock
   input wire logic rstn,       // Sync reset, active low
   input wire logic run,        // Counting allowed
   input wire logic restart,    // Return to start
   input wire logic [1:0] sel,  // Interval select
   output logic tmo_pulse,      // One-cycle time-out
   output cnt_t count           // Chain value
);
   typedef struct packed {
      cnt_t cnt;
      logic tmo;
   } div_st_t;

   div_st_t st;
   div_st_t next_st;

   function automatic cnt_t tap_mask(input logic [1:0] s);
      int lg;
      case (s)
         2'h0: lg = IVL0_LOG2;
         2'h1: lg = IVL1_LOG2;
         2'h2: lg = IVL2_LOG2;
         default: lg = IVL3_LOG2;
      endcase
      return (cnt_t'(1) << lg) - cnt_t'(1); // [RULE_15]
   endfunction

   always_comb begin
      next_st = st;
      next_st.tmo = 1'b0;
      if (restart) begin
         next_st.cnt = '0; // [RULE_02]
      end else if (run) begin
         next_st.cnt = st.cnt + cnt_t'(1); // [RULE_01] [RULE_14]
         if ((st.cnt & tap_mask(sel)) == tap_mask(sel)) begin
            next_st.tmo = 1'b1; // [RULE_01]
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tmo_pulse = st.tmo;
   assign count = st.cnt;
endmodule // wd_divider_chain
`default_nettype wire

// ===== wdt_pkg.sv
// Shared constants and types for the watchdog timer block
`default_nettype none
package wdt_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLKS_PER_MC = 4;
   localparam int unsigned TA_KEYGAP_MC = 4;
   localparam int unsigned TA_WINDOW_MC = 3;
   localparam int unsigned RST_PULSE_MC = 2;
   localparam logic [4:0] TA_KEYGAP_CLKS = 5'(TA_KEYGAP_MC * CLKS_PER_MC);
   localparam logic [4:0] TA_WINDOW_CLKS = 5'(TA_WINDOW_MC * CLKS_PER_MC);
   localparam logic [3:0] RST_PULSE_CLKS = 4'(RST_PULSE_MC * CLKS_PER_MC);
   localparam logic [9:0] POST_TIMEOUT_TICKS = 10'h200;
   localparam int unsigned CNT_W = 26;
   typedef logic [CNT_W-1:0] cnt_t;
   // ---------------------------------------------------------------
   // Timed-access keys
   // ---------------------------------------------------------------
   localparam logic [7:0] TA_KEY1 = 8'haa;
   localparam logic [7:0] TA_KEY2 = 8'h55;
   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TA = 8'h04;
   localparam logic [7:0] OFS_GIE = 8'h08;
   localparam logic [7:0] OFS_EVT_STAT = 8'h0c;
   localparam logic [7:0] OFS_EVT_EN = 8'h10;
   localparam logic [7:0] OFS_EVT_CLR = 8'h14;
   localparam logic [7:0] OFS_COUNT = 8'h18;
   // Control register fields
   localparam int unsigned CTL_RESTART = 0;
   localparam int unsigned CTL_RST_EN = 1;
   localparam int unsigned CTL_CAUSE = 2;
   localparam int unsigned CTL_TMO = 3;
   localparam int unsigned CTL_SEL_LO = 4;
   localparam int unsigned CTL_SEL_HI = 5;
   localparam int unsigned CTL_IRQ_EN = 6;
   localparam int unsigned CTL_RUN = 7;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Event status bits
   localparam int unsigned EVT_TMO = 0;
   localparam int unsigned EVT_RST = 1;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // ---------------------------------------------------------------
   // States
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      PH_COUNT = 2'b00,
      PH_GRACE = 2'b01,
      PH_RESET = 2'b10
   } phase_t;
   typedef enum logic [1:0] {
      G_IDLE = 2'b00,
      G_KEY1 = 2'b01,
      G_OPEN = 2'b10
   } gate_t;
endpackage
`default_nettype wire
